// >>> src/lut_store.sv
// Purpose: two-bank 1024 x 8 lookup storage in flip-flops
// Assumes: one write port, two combinational read ports
// Notes:   contents have no reset; clock enable freezes writes

`timescale 1ns/100ps

module lut_store (
	// clock
	input  wire logic       clock,
	input  wire logic       ce,
	// write port
	input  wire logic       wr_en,
	input  wire logic       wr_bank,
	input  wire logic [9:0] wr_idx,
	input  wire logic [7:0] wr_data,
	// pixel read port
	input  wire logic       rda_bank,
	input  wire logic [9:0] rda_idx,
	output logic      [7:0] rda_data,
	// host read port
	input  wire logic       rdb_bank,
	input  wire logic [9:0] rdb_idx,
	output logic      [7:0] rdb_data
);

	logic [7:0] mem [2][pix_map_pkg::LUT_DEPTH];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (ce && wr_en) begin
			mem[wr_bank][wr_idx] <= wr_data;
		end
	end

	assign rda_data = mem[rda_bank][rda_idx];
	assign rdb_data = mem[rdb_bank][rdb_idx];

endmodule : lut_store

// >>> src/pix_map_pkg.sv
// Purpose: shared constants and carriers for the pixel conversion stage
// Assumes: 10-bit sensor samples in, 8-bit pixels out
// Notes:   register offsets are word indexes on the plain register port

package pix_map_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int          PIX_W       = 10;
	localparam int          OUT_W       = 8;
	localparam int          LUT_DEPTH   = 1024;
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam int          SCALE_SHIFT = 10;

	// ----------------------------------------------------------------
	// reset values and mapping constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  GAIN_RST    = 8'h00;
	localparam logic [9:0]  BRIGHT_RST  = 10'h2d5;
	localparam logic [10:0] GAIN_BASE   = 11'h100;
	localparam logic [10:0] GAIN_STEP   = 11'h003;
	localparam logic [7:0]  OUT_MAX     = 8'hff;
	localparam logic        LUT_EN_RST  = 1'b0;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_GAIN    = 4'h1;
	localparam logic [3:0]  REG_BRIGHT  = 4'h2;
	localparam logic [3:0]  REG_LUT_IDX = 4'h3;
	localparam logic [3:0]  REG_LUT_DAT = 4'h4;
	localparam logic [3:0]  REG_STATUS  = 4'h5;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          CTRL_LUT_EN  = 0;
	localparam int          CTRL_SWAP    = 1;
	localparam int          STAT_LUT_EN  = 0;
	localparam int          STAT_BANK    = 1;
	localparam int          STAT_SWAP_PD = 2;
	localparam int          STAT_GAIN_LO = 8;
	localparam int          STAT_BRT_LO  = 16;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             sof;
		logic             valid;
		logic [PIX_W-1:0] data;
	} pix_in_s;

	typedef struct packed {
		logic             sof;
		logic             valid;
		logic [OUT_W-1:0] data;
	} pix_out_s;

	typedef struct packed {
		logic             lut_en;
		logic [7:0]       gain;
		logic [PIX_W-1:0] bright;
	} map_cfg_s;

endpackage : pix_map_pkg

// >>> src/pixel_gain_brightness_lut.sv
// Purpose: 10-bit to 8-bit pixel conversion, gain/brightness or table
// Assumes: sof marks the first pixel of a frame; inputs synchronous
// Notes:   one cycle from input pixel to output pixel
//
// Contract
// - Gain zero maps the full 10-bit range onto 0..255 as 0 dB.
// - Gain above zero maps a narrower sensor span onto full output.
// - Gain is an 8-bit value from 0 to 255 spanning 0 to 12 dB.
// - Gain 85 (6 dB) roughly doubles output, 127 becomes about 254.
// - Brightness resets to 725 and higher values raise the output.
// - Brightness below 725 lowers the output for a given input.
// - With the table off, output comes from gain and brightness.
// - With the table on, gain and brightness are ignored.
// - The table holds 1024 bytes indexed by the 10-bit sample.

`timescale 1ns/100ps

module pixel_gain_brightness_lut (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	// pixel stream
	input  wire pix_map_pkg::pix_in_s  pix_in,
	output pix_map_pkg::pix_out_s      pix_out
);

	// ----------------------------------------------------------------
	// mapping arithmetic
	// ----------------------------------------------------------------
	function automatic logic [7:0] map_pixel(
		input logic [9:0] pix,
		input logic [7:0] gain,
		input logic [9:0] bright
	);
		logic signed [12:0] shifted;
		logic        [10:0] mult;
		logic signed [24:0] prod;
		shifted = $signed({3'h0, pix}) + $signed({3'h0, bright})
			- $signed({3'h0, pix_map_pkg::BRIGHT_RST});
		mult = pix_map_pkg::GAIN_BASE
			+ 11'(gain) * pix_map_pkg::GAIN_STEP;
		prod = shifted * $signed({1'b0, mult});
		if (prod < 0) begin
			map_pixel = 8'h00;
		end else if (prod[24:pix_map_pkg::SCALE_SHIFT] > 15'h00ff) begin
			map_pixel = pix_map_pkg::OUT_MAX;
		end else begin
			map_pixel = prod[17:10];
		end
	endfunction : map_pixel

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pix_map_pkg::map_cfg_s sw_cfg_reg;
	pix_map_pkg::map_cfg_s act_cfg_reg;
	pix_map_pkg::map_cfg_s cur_cfg;
	logic                  swap_pend_reg;
	logic                  act_bank_reg;
	logic                  cur_bank;
	logic [9:0]            lut_idx_reg;
	logic [7:0]            lut_pix_byte;
	logic [7:0]            lut_host_byte;
	logic [7:0]            out_next;
	logic                  lut_wr;
	logic                  frame_edge;

	assign frame_edge = pix_in.sof && pix_in.valid;
	assign lut_wr     = reg_wr && (reg_addr == pix_map_pkg::REG_LUT_DAT);

	// ----------------------------------------------------------------
	// software settings
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sw_cfg_reg.lut_en <= pix_map_pkg::LUT_EN_RST;
			sw_cfg_reg.gain   <= pix_map_pkg::GAIN_RST;
			sw_cfg_reg.bright <= pix_map_pkg::BRIGHT_RST;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				pix_map_pkg::REG_CTRL: begin
					sw_cfg_reg.lut_en <= reg_wdata[pix_map_pkg::CTRL_LUT_EN];
				end
				pix_map_pkg::REG_GAIN: begin
					sw_cfg_reg.gain <= reg_wdata[7:0];
				end
				pix_map_pkg::REG_BRIGHT: begin
					sw_cfg_reg.bright <= reg_wdata[9:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// table index, auto-increment after each data write
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lut_idx_reg <= 10'h000;
		end else if (ce) begin
			if (reg_wr && reg_addr == pix_map_pkg::REG_LUT_IDX) begin
				lut_idx_reg <= reg_wdata[9:0];
			end else if (lut_wr) begin
				lut_idx_reg <= lut_idx_reg + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// bank swap request, set wins over frame-start clear
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			swap_pend_reg <= 1'b0;
		end else if (ce) begin
			if (reg_wr && reg_addr == pix_map_pkg::REG_CTRL
				&& reg_wdata[pix_map_pkg::CTRL_SWAP]) begin
				swap_pend_reg <= 1'b1;
			end else if (frame_edge) begin
				swap_pend_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame-start capture of settings and table bank
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			act_cfg_reg.lut_en <= pix_map_pkg::LUT_EN_RST;
			act_cfg_reg.gain   <= pix_map_pkg::GAIN_RST;
			act_cfg_reg.bright <= pix_map_pkg::BRIGHT_RST;
			act_bank_reg       <= 1'b0;
		end else if (ce && frame_edge) begin
			act_cfg_reg  <= sw_cfg_reg;
			act_bank_reg <= cur_bank;
		end
	end

	assign cur_cfg  = frame_edge ? sw_cfg_reg : act_cfg_reg;
	assign cur_bank = (frame_edge && swap_pend_reg) ? !act_bank_reg
		: act_bank_reg;

	// ----------------------------------------------------------------
	// table storage, host writes the bank other than act_bank_reg
	// ----------------------------------------------------------------
	lut_store u_lut (
		.clock    (clock),
		.ce       (ce),
		.wr_en    (lut_wr && rst_n),
		.wr_bank  (!act_bank_reg),
		.wr_idx   (lut_idx_reg),
		.wr_data  (reg_wdata[7:0]),
		.rda_bank (cur_bank),
		.rda_idx  (pix_in.data),
		.rda_data (lut_pix_byte),
		.rdb_bank (!act_bank_reg),
		.rdb_idx  (lut_idx_reg),
		.rdb_data (lut_host_byte)
	);

	// ----------------------------------------------------------------
	// pixel path
	// ----------------------------------------------------------------
	always_comb begin
		if (cur_cfg.lut_en) begin
			out_next = lut_pix_byte;
		end else begin
			out_next = map_pixel(pix_in.data, cur_cfg.gain,
				cur_cfg.bright);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pix_out <= '0;
		end else if (ce) begin
			pix_out.sof   <= pix_in.sof && pix_in.valid;
			pix_out.valid <= pix_in.valid;
			if (pix_in.valid) begin
				pix_out.data <= out_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (ce) begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					pix_map_pkg::REG_CTRL: begin
						reg_rdata[pix_map_pkg::CTRL_LUT_EN] <= sw_cfg_reg.lut_en;
						reg_rdata[pix_map_pkg::CTRL_SWAP]   <= swap_pend_reg;
					end
					pix_map_pkg::REG_GAIN: begin
						reg_rdata[7:0] <= sw_cfg_reg.gain;
					end
					pix_map_pkg::REG_BRIGHT: begin
						reg_rdata[9:0] <= sw_cfg_reg.bright;
					end
					pix_map_pkg::REG_LUT_IDX: begin
						reg_rdata[9:0] <= lut_idx_reg;
					end
					pix_map_pkg::REG_LUT_DAT: begin
						reg_rdata[7:0] <= lut_host_byte;
					end
					pix_map_pkg::REG_STATUS: begin
						reg_rdata[pix_map_pkg::STAT_LUT_EN]  <= act_cfg_reg.lut_en;
						reg_rdata[pix_map_pkg::STAT_BANK]    <= act_bank_reg;
						reg_rdata[pix_map_pkg::STAT_SWAP_PD] <= swap_pend_reg;
						reg_rdata[15:8]  <= act_cfg_reg.gain;
						reg_rdata[25:16] <= act_cfg_reg.bright;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_zero_gain_map: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en && cur_cfg.gain == 8'h00
			&& cur_cfg.bright == pix_map_pkg::BRIGHT_RST)
		|=> pix_out.data == $past(pix_in.data[9:2]))
		else $error("zero gain output not sample over four");

	a_gain_narrows: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en && cur_cfg.gain != 8'h00)
		|=> pix_out.data >= map_pixel($past(pix_in.data), 8'h00,
			$past(cur_cfg.bright)))
		else $error("gain above zero lowered output");

	a_six_db_double: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en && cur_cfg.gain == 8'h55
			&& cur_cfg.bright == pix_map_pkg::BRIGHT_RST
			&& pix_in.data == 10'h1fe)
		|=> pix_out.data == 8'hfe)
		else $error("6 dB setting did not double output");

	a_bright_up: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en
			&& cur_cfg.bright > pix_map_pkg::BRIGHT_RST)
		|=> pix_out.data >= map_pixel($past(pix_in.data),
			$past(cur_cfg.gain), pix_map_pkg::BRIGHT_RST))
		else $error("higher brightness lowered output");

	a_bright_down: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en
			&& cur_cfg.bright < pix_map_pkg::BRIGHT_RST)
		|=> pix_out.data <= map_pixel($past(pix_in.data),
			$past(cur_cfg.gain), pix_map_pkg::BRIGHT_RST))
		else $error("lower brightness raised output");

	a_lut_select: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && cur_cfg.lut_en)
		|=> pix_out.valid && pix_out.data == $past(lut_pix_byte))
		else $error("table output not taken from table");

	a_sat_high: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en && pix_in.data == 10'h3ff
			&& cur_cfg.bright >= pix_map_pkg::BRIGHT_RST)
		|=> pix_out.data == pix_map_pkg::OUT_MAX)
		else $error("bright pixel did not saturate at 255");

	a_sat_low: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && pix_in.valid && !cur_cfg.lut_en && pix_in.data == 10'h000
			&& cur_cfg.bright <= pix_map_pkg::BRIGHT_RST)
		|=> pix_out.data == 8'h00)
		else $error("dark pixel did not clamp at zero");

	a_frame_hold: assert property (
		@(posedge clock) disable iff (!rst_n)
		!(ce && frame_edge) |=> $stable(act_cfg_reg) && $stable(act_bank_reg))
		else $error("mapping changed inside a frame");

	a_frame_take: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ce && frame_edge) |=> act_cfg_reg == $past(sw_cfg_reg))
		else $error("settings not taken at frame start");

endmodule : pixel_gain_brightness_lut

// >>> testbench/pix_sensor_model.sv
// Purpose: sensor side of the pixel stream
// Assumes: bench asks for one pixel per cycle through go
// Notes:   idle data inverts every cycle so stale values never match

`timescale 1ns/100ps

module pix_sensor_model (
	// clock
	input  wire logic            clock,
	// request
	input  wire logic            go,
	input  wire logic            sof_req,
	input  wire logic [9:0]      val,
	// stream
	output pix_map_pkg::pix_in_s pix_in
);
	initial pix_in = '0;

	always @(posedge clock) begin
		if (go) begin
			pix_in <= {sof_req, 1'b1, val};
		end else begin
			pix_in <= {1'b0, 1'b0, ~pix_in.data};
		end
	end
endmodule : pix_sensor_model

// >>> testbench/test_pixel_gain_brightness_lut.sv
// Purpose: self-checking bench for the pixel conversion stage
// Assumes: clock enable high except in its own freeze test
// Notes:   expected pixels queued by the driver, popped by a monitor

`timescale 1ns/100ps

module test_pixel_gain_brightness_lut;
	// ----------------------------------------------------------------
	// signals and shadow state
	// ----------------------------------------------------------------
	logic                  clock      = 1'b0;
	logic                  rst_n      = 1'b0;
	logic                  ce         = 1'b1;
	logic [3:0]            reg_addr   = 4'h0;
	logic [31:0]           reg_wdata  = 32'h0;
	logic                  reg_wr     = 1'b0;
	logic                  reg_rd     = 1'b0;
	logic [31:0]           reg_rdata;
	logic                  go         = 1'b0;
	logic                  sof_req    = 1'b0;
	logic [9:0]            val        = 10'h000;
	pix_map_pkg::pix_in_s  pix_in;
	pix_map_pkg::pix_out_s pix_out;
	int                    error_cnt  = 0;
	int                    num_checks = 0;
	logic [8:0]            exp_q[$];
	logic [7:0]            tbl[1024];
	logic [7:0]            sw_gain    = 8'h00;
	logic [9:0]            sw_bright  = 10'h2d5;
	logic                  sw_lut     = 1'b0;
	logic [7:0]            act_gain   = 8'h00;
	logic [9:0]            act_bright = 10'h2d5;
	logic                  act_lut    = 1'b0;
	logic                  bank       = 1'b0;
	logic                  pend       = 1'b0;
	logic [7:0]            gl[8] = '{8'h00, 8'h1c, 8'h2b, 8'h55,
		8'h80, 8'haa, 8'hd5, 8'hff};
	logic [9:0]            bl[4] = '{10'h384, 10'h1f4, 10'h000, 10'h3ff};

	always #20 clock = ~clock;

	pixel_gain_brightness_lut i_dut (
		.clock(clock), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pix_in(pix_in), .pix_out(pix_out));

	pix_sensor_model i_sensor (.clock(clock), .go(go), .sof_req(sof_req),
		.val(val), .pix_in(pix_in));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		case (a)
			pix_map_pkg::REG_CTRL: begin
				sw_lut = d[0];
				pend   = pend | d[1];
			end
			pix_map_pkg::REG_GAIN:   sw_gain = d[7:0];
			pix_map_pkg::REG_BRIGHT: sw_bright = d[9:0];
			default: ;
		endcase
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, exp);
	endtask : rd_chk

	function automatic logic [7:0] gb_map(logic [9:0] p, logic [7:0] g,
		logic [9:0] b);
		int r;
		r = ((int'(p) + int'(b) - 725) * (256 + 3 * int'(g))) >>> 10;
		return (r < 0) ? 8'h00 : (r > 255) ? 8'hff : 8'(r);
	endfunction : gb_map

	function automatic logic [31:0] stat_exp();
		return {6'h00, act_bright, act_gain, 5'h00, pend, bank, act_lut};
	endfunction : stat_exp

	task px(input logic s, input logic [9:0] v);
		@(posedge clock);
		if (s) begin
			act_gain   = sw_gain;
			act_bright = sw_bright;
			act_lut    = sw_lut;
			bank       = bank ^ pend;
			pend       = 1'b0;
		end
		go      <= 1'b1;
		sof_req <= s;
		val     <= v;
		exp_q.push_back({s, act_lut ? tbl[v] : gb_map(v, act_gain, act_bright)});
	endtask : px

	task stop_px;
		@(posedge clock);
		go <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : stop_px

	task frm(input int n);
		px(1'b1, 10'h000);
		px(1'b0, 10'h3ff);
		px(1'b0, 10'h1fe);
		for (int i = 0; i < n; i++) begin
			px(1'b0, 10'($urandom));
		end
		stop_px();
	endtask : frm

	always @(negedge clock) begin
		if (pix_out.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(32'h1, 32'h0);
			end else begin
				chk({pix_out.sof, pix_out.data}, exp_q.pop_front());
			end
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(17854));
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk(pix_map_pkg::REG_STATUS, 32'h02d50000);
		rd_chk(pix_map_pkg::REG_BRIGHT, 32'h000002d5);
		wr(4'h6, 32'hffffffff);
		rd_chk(4'h6, 32'h0);
		frm(20);
		$display("reset and unity gain test done");
		foreach (gl[i]) begin
			wr(pix_map_pkg::REG_GAIN, {24'h0, gl[i]});
			frm(12);
		end
		$display("gain test done");
		wr(pix_map_pkg::REG_GAIN, 32'd28);
		foreach (bl[i]) begin
			wr(pix_map_pkg::REG_BRIGHT, {22'h0, bl[i]});
			frm(12);
		end
		$display("brightness test done");
		px(1'b1, 10'h200);
		stop_px();
		wr(pix_map_pkg::REG_GAIN, 32'h80);
		wr(pix_map_pkg::REG_BRIGHT, 32'd725);
		for (int i = 0; i < 6; i++) begin
			px(1'b0, 10'($urandom));
		end
		stop_px();
		frm(6);
		$display("frame boundary test done");
		ce <= 1'b0;
		wr(pix_map_pkg::REG_GAIN, 32'haa);
		sw_gain = 8'h80;
		@(posedge clock);
		ce <= 1'b1;
		rd_chk(pix_map_pkg::REG_GAIN, 32'h80);
		$display("clock enable freeze test done");
		wr(pix_map_pkg::REG_LUT_IDX, 32'h0);
		for (int i = 0; i < 1024; i++) begin
			tbl[i] = 8'($urandom);
			wr(pix_map_pkg::REG_LUT_DAT, {24'h0, tbl[i]});
		end
		wr(pix_map_pkg::REG_LUT_IDX, 32'd5);
		rd_chk(pix_map_pkg::REG_LUT_DAT, {24'h0, tbl[5]});
		wr(pix_map_pkg::REG_CTRL, 32'h3);
		rd_chk(pix_map_pkg::REG_STATUS, stat_exp());
		frm(40);
		rd_chk(pix_map_pkg::REG_STATUS, stat_exp());
		$display("lookup table test done");
		chk(exp_q.size(), 32'h0);
		stop_test();
	end

	initial begin
		#(40 * 10000);
		error_cnt++;
		stop_test();
	end
endmodule : test_pixel_gain_brightness_lut
